// >>> eipc_pkg.sv
// package for the extended interrupt priority and pin configuration block
package eipc_pkg;
   localparam logic [11:0] ADDR_ENABLE2   = 12'h0e7 << 2;
   localparam logic [11:0] ADDR_PRIO1     = 12'h0f6 << 2;
   localparam logic [11:0] ADDR_PRIO2     = 12'h0f7 << 2;
   localparam logic [11:0] ADDR_PINCFG    = 12'h0e8 << 2;
   localparam logic [11:0] ADDR_GLOBAL    = 12'h0e9 << 2;
   localparam logic [11:0] ADDR_SKIP      = 12'h0ea << 2;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h0eb << 2;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h0ec << 2;
   localparam logic [11:0] ADDR_SVC       = 12'h0ed << 2;
   localparam logic [7:0]  RST_PINCFG     = 8'h01;
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_SKIP       = 8'h00;
   localparam int          BIT_GLOBAL     = 0;
   localparam int          BIT_VBUS       = 0;
   localparam int          NSRC           = 9;
   localparam int          SRC_VBUS       = 8;
   localparam logic [3:0]  NO_SRC         = 4'hf;
   // irq status bit positions
   localparam int          EV_TAKE_HI     = 0;
   localparam int          EV_TAKE_LO     = 1;
   localparam int          EV_PREEMPT     = 2;

   typedef struct packed {
      logic       one_polarity;
      logic [2:0] one_pin_sel;
      logic       zero_polarity;
      logic [2:0] zero_pin_sel;
   } eipc_pincfg_s;

   typedef struct packed {
      logic       valid;
      logic       high;
      logic [3:0] id;
   } eipc_req_s;
endpackage

// >>> eipc_src_model.sv
// peripheral request sources and cpu service model facing the interrupt block
module eipc_src_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [8:0] want,
   input  wire logic       cpu_irq_valid,
   input  wire logic [3:0] cpu_irq_id,
   output logic      [7:0] src_req,
   output logic            vbus_level,
   output logic            svc_done
);
   logic [8:0] taken;
   logic [1:0] done_dly;

   // a routine clears its source flag once taken; dropping want forgets it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         taken    <= 9'h000;
         done_dly <= 2'b00;
      end else begin
         taken    <= (taken | ((cpu_irq_valid && cpu_irq_id < 4'h9) ? (9'h001 << cpu_irq_id) : 9'h000)) & want;
         done_dly <= {done_dly[0], cpu_irq_valid};
      end
   end

   assign {vbus_level, src_req} = want & ~taken;
   // short routine: every taken request ends two cycles later
   assign svc_done = done_dly[1];
endmodule // eipc_src_model

// >>> eipc_top.sv
// extended interrupt priority, bus-voltage enable and external input pin selection
//
// Implementation choice: the APB interface to the registers.
module eipc_top (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port0_pin,
   input  wire logic [7:0]  periph_want_pin,
   output logic      [7:0]  periph_pin_grant,
   input  wire logic [1:0]  ext_in_edge_mode,
   output logic             ext_in_zero,
   output logic             ext_in_one,
   input  wire logic [7:0]  src_req,
   input  wire logic [7:0]  src_en,
   input  wire logic        vbus_level,
   input  wire logic        svc_done,
   output logic             cpu_irq_valid,
   output logic             cpu_irq_high,
   output logic      [3:0]  cpu_irq_id,
   output logic             irq
);
   logic [7:0]               ext_priority_bank1;
   logic                     bus_voltage_irq_en;
   logic                     bus_voltage_prio;
   eipc_pkg::eipc_pincfg_s   ext_input_pin_config;
   logic                     global_irq_enable;
   logic [7:0]               port_zero_skip_mask;
   logic [2:0]               irq_stat;
   logic [2:0]               irq_mask;
   logic [7:0]               pin_s1;
   logic [7:0]               pin_s2;
   logic                     vbus_s1;
   logic                     vbus_s2;
   logic                     zero_lvl;
   logic                     one_lvl;
   logic                     zero_prev;
   logic                     one_prev;
   logic [eipc_pkg::NSRC-1:0] pend;
   logic [eipc_pkg::NSRC-1:0] prio;
   eipc_pkg::eipc_req_s      next_req;
   eipc_pkg::eipc_req_s      req;
   logic                     in_svc_lo;
   logic                     in_svc_hi;
   logic                     take;
   logic                     wr;
   logic                     rd_ok;
   logic [2:0]               ev;

   assign wr      = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // register writes; unused bits of the bus-voltage registers are dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_priority_bank1   <= eipc_pkg::RST_ZERO;
         bus_voltage_irq_en   <= 1'b0;
         bus_voltage_prio     <= 1'b0;
         ext_input_pin_config <= eipc_pkg::RST_PINCFG;
         global_irq_enable    <= 1'b0;
         port_zero_skip_mask  <= eipc_pkg::RST_SKIP;
         irq_mask             <= 3'h0;
      end else if (wr) begin
         unique case (paddr)
            eipc_pkg::ADDR_PRIO1:    ext_priority_bank1 <= pwdata[7:0];
            eipc_pkg::ADDR_ENABLE2:  bus_voltage_irq_en <= pwdata[eipc_pkg::BIT_VBUS];
            eipc_pkg::ADDR_PRIO2:    bus_voltage_prio <= pwdata[eipc_pkg::BIT_VBUS];
            eipc_pkg::ADDR_PINCFG:   ext_input_pin_config <= pwdata[7:0];
            eipc_pkg::ADDR_GLOBAL:   global_irq_enable <= pwdata[eipc_pkg::BIT_GLOBAL];
            eipc_pkg::ADDR_SKIP:     port_zero_skip_mask <= pwdata[7:0];
            eipc_pkg::ADDR_IRQ_MASK: irq_mask <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      prdata = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (paddr)
         eipc_pkg::ADDR_PRIO1:    prdata[7:0] = ext_priority_bank1;
         eipc_pkg::ADDR_ENABLE2:  prdata[0] = bus_voltage_irq_en;
         eipc_pkg::ADDR_PRIO2:    prdata[0] = bus_voltage_prio;
         eipc_pkg::ADDR_PINCFG:   prdata[7:0] = ext_input_pin_config;
         eipc_pkg::ADDR_GLOBAL:   prdata[0] = global_irq_enable;
         eipc_pkg::ADDR_SKIP:     prdata[7:0] = port_zero_skip_mask;
         eipc_pkg::ADDR_IRQ_STAT: prdata[2:0] = irq_stat;
         eipc_pkg::ADDR_IRQ_MASK: prdata[2:0] = irq_mask;
         eipc_pkg::ADDR_SVC:      prdata[1:0] = {in_svc_hi, in_svc_lo};
         default:                 rd_ok = 1'b0;
      endcase
   end

   // pins and vbus are asynchronous to mclk
   // pins reset to their pulled-up idle level: no false edge after reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1  <= '1;
         pin_s2  <= '1;
         vbus_s1 <= 1'b0;
         vbus_s2 <= 1'b0;
      end else begin
         pin_s1  <= port0_pin;
         pin_s2  <= pin_s1;
         vbus_s1 <= vbus_level;
         vbus_s2 <= vbus_s1;
      end
   end

   // read-only tap of the pin: routing is untouched
   always_comb begin
      zero_lvl = pin_s2[ext_input_pin_config.zero_pin_sel]
                 ^ ~ext_input_pin_config.zero_polarity;
      one_lvl  = pin_s2[ext_input_pin_config.one_pin_sel]
                 ^ ~ext_input_pin_config.one_polarity;
   end

   assign periph_pin_grant = periph_want_pin & ~port_zero_skip_mask;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         zero_prev   <= 1'b0;
         one_prev    <= 1'b0;
         ext_in_zero <= 1'b0;
         ext_in_one  <= 1'b0;
      end else begin
         zero_prev   <= zero_lvl;
         one_prev    <= one_lvl;
         // edge mode after polarity: asserted-going transition only
         ext_in_zero <= ext_in_edge_mode[0] ? (zero_lvl && !zero_prev) : zero_lvl;
         ext_in_one  <= ext_in_edge_mode[1] ? (one_lvl && !one_prev) : one_lvl;
      end
   end

   // bank bits 0..7 map to smbus..timer three in bit order
   assign prio = {bus_voltage_prio, ext_priority_bank1};
   assign pend = {vbus_s2 & bus_voltage_irq_en,
                  src_req & src_en} & {eipc_pkg::NSRC{global_irq_enable}};

   function automatic eipc_pkg::eipc_req_s pick(input logic [eipc_pkg::NSRC-1:0] p);
      pick = '{valid: 1'b0, high: 1'b0, id: eipc_pkg::NO_SRC};
      for (int i = eipc_pkg::NSRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            pick = '{valid: 1'b1, high: 1'b0, id: 4'(i)};
         end
      end
   endfunction

   // high level first; low only when no service is active
   always_comb begin
      next_req = pick(pend & prio);
      if (next_req.valid) begin
         next_req.high  = 1'b1;
         next_req.valid = !in_svc_hi;
      end else begin
         next_req       = pick(pend & ~prio);
         next_req.valid = next_req.valid && !in_svc_hi && !in_svc_lo;
      end
   end

   assign take = req.valid;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req       <= '{valid: 1'b0, high: 1'b0, id: eipc_pkg::NO_SRC};
         in_svc_lo <= 1'b0;
         in_svc_hi <= 1'b0;
      end else begin
         req <= take ? '{valid: 1'b0, high: 1'b0, id: eipc_pkg::NO_SRC} : next_req;
         if (take && req.high) begin
            in_svc_hi <= 1'b1;
         end else if (svc_done && in_svc_hi) begin
            in_svc_hi <= 1'b0;
         end
         if (take && !req.high) begin
            in_svc_lo <= 1'b1;
         end else if (svc_done && !in_svc_hi) begin
            in_svc_lo <= 1'b0;
         end
      end
   end

   assign cpu_irq_valid = req.valid;
   assign cpu_irq_high  = req.high;
   assign cpu_irq_id    = req.id;

   assign ev = {take && req.high && in_svc_lo, take && !req.high, take && req.high};

   // set wins over the write-one clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= (irq_stat & ~((wr && paddr == eipc_pkg::ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // assertions
   property p_prio_bit7;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO1) |=> prio[7] == $past(pwdata[7]);
   endproperty
   a_prio_bit7: assert property (p_prio_bit7) else $error("timer three priority not stored");

   property p_unused_zero;
      @(posedge mclk) disable iff (!rst_n)
      (paddr == eipc_pkg::ADDR_ENABLE2 || paddr == eipc_pkg::ADDR_PRIO2) |-> prdata[31:1] == 31'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

   property p_vbus_gate;
      @(posedge mclk) disable iff (!rst_n)
      !bus_voltage_irq_en |-> !pend[eipc_pkg::SRC_VBUS];
   endproperty
   a_vbus_gate: assert property (p_vbus_gate) else $error("vbus pending while disabled");

   property p_global_gate;
      @(posedge mclk) disable iff (!rst_n)
      !global_irq_enable ##1 !global_irq_enable |-> !next_req.valid;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("request with global enable off");

   property p_hi_first;
      @(posedge mclk) disable iff (!rst_n)
      (|(pend & prio) && !in_svc_hi && !req.valid) |=> (req.valid && req.high);
   endproperty
   a_hi_first: assert property (p_hi_first) else $error("high priority not served first");

   property p_zero_pin;
      @(posedge mclk) disable iff (!rst_n)
      (!ext_in_edge_mode[0] && $stable(ext_input_pin_config))
      |=> ext_in_zero == ($past(pin_s2[ext_input_pin_config.zero_pin_sel])
                          ~^ $past(ext_input_pin_config.zero_polarity));
   endproperty
   a_zero_pin: assert property (p_zero_pin) else $error("input zero level wrong");

   property p_one_pin;
      @(posedge mclk) disable iff (!rst_n)
      (!ext_in_edge_mode[1] && $stable(ext_input_pin_config))
      |=> ext_in_one == ($past(pin_s2[ext_input_pin_config.one_pin_sel])
                         ~^ $past(ext_input_pin_config.one_polarity));
   endproperty
   a_one_pin: assert property (p_one_pin) else $error("input one level wrong");

   property p_skip;
      @(posedge mclk) disable iff (!rst_n)
      (port_zero_skip_mask != 8'h00) |-> (periph_pin_grant & port_zero_skip_mask) == 8'h00;
   endproperty
   a_skip: assert property (p_skip) else $error("skipped pin granted");

   property p_edge_pulse;
      @(posedge mclk) disable iff (!rst_n)
      (ext_in_edge_mode[0] && ext_in_zero) ##1 ext_in_edge_mode[0] |-> !ext_in_zero;
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("edge mode pulse too long");

   property p_reset_cfg;
      @(posedge mclk) $rose(rst_n) |-> ext_input_pin_config == eipc_pkg::RST_PINCFG && prio == '0;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("reset values wrong");

   property p_cmp_prio;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO1) |=> prio[6:5] == $past(pwdata[6:5]);
   endproperty
   a_cmp_prio: assert property (p_cmp_prio) else $error("comparator priority not stored");

   property p_pca_prio;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO1) |=> prio[4] == $past(pwdata[4]);
   endproperty
   a_pca_prio: assert property (p_pca_prio) else $error("counter array priority not stored");

   property p_conv_prio;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO1) |=> prio[3] == $past(pwdata[3]);
   endproperty
   a_conv_prio: assert property (p_conv_prio) else $error("conversion done priority not stored");

   property p_low_bank_prio;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO1) |=> prio[2:0] == $past(pwdata[2:0]);
   endproperty
   a_low_bank_prio: assert property (p_low_bank_prio) else $error("smbus window usb priority not stored");

   property p_vbus_prio;
      @(posedge mclk) disable iff (!rst_n)
      (wr && paddr == eipc_pkg::ADDR_PRIO2) |=> prio[eipc_pkg::SRC_VBUS] == $past(pwdata[eipc_pkg::BIT_VBUS]);
   endproperty
   a_vbus_prio: assert property (p_vbus_prio) else $error("bus voltage priority not stored");

   property p_global_src;
      @(posedge mclk) disable iff (!rst_n)
      !global_irq_enable |-> pend == '0;
   endproperty
   a_global_src: assert property (p_global_src) else $error("source pending with global enable off");

   property p_low_idle;
      @(posedge mclk) disable iff (!rst_n)
      (req.valid && !req.high) |-> !in_svc_hi && !in_svc_lo;
   endproperty
   a_low_idle: assert property (p_low_idle) else $error("low request during active service");

   property p_one_pulse;
      @(posedge mclk) disable iff (!rst_n)
      (ext_in_edge_mode[1] && ext_in_one) ##1 ext_in_edge_mode[1] |-> !ext_in_one;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("input one pulse too long");

   property p_stat_set;
      @(posedge mclk) disable iff (!rst_n)
      ev[eipc_pkg::EV_TAKE_LO] |=> irq_stat[eipc_pkg::EV_TAKE_LO];
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("low take not recorded");

   property p_unmapped_zero;
      @(posedge mclk) disable iff (!rst_n)
      !rd_ok |-> prdata == 32'h0000_0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

   c_high_take: cover property (@(posedge mclk) disable iff (!rst_n) take && req.high);
   c_preempt:   cover property (@(posedge mclk) disable iff (!rst_n) ev[eipc_pkg::EV_PREEMPT]);
   c_vbus:      cover property (@(posedge mclk) disable iff (!rst_n) take && req.id == 4'(eipc_pkg::SRC_VBUS));
   c_irq:       cover property (@(posedge mclk) disable iff (!rst_n) irq);
   c_edge:      cover property (@(posedge mclk) disable iff (!rst_n) ext_in_edge_mode[0] && ext_in_zero);
endmodule // eipc_top

// >>> eipc_top_test.sv
// self-checking bench for the extended interrupt priority and pin configuration block
module eipc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [11:0] a;
      logic [7:0]  d;
      logic [7:0]  e;
   } eipc_row_s;
   logic        mclk      = 1'b0;
   logic        rst_n     = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0000_0000;
   logic [7:0]  port0_pin = 8'h00;
   logic [7:0]  want_pin  = 8'hff;
   logic [7:0]  src_en    = 8'hff;
   logic [1:0]  edge_mode = 2'b00;
   logic [8:0]  want      = 9'h000;
   logic [31:0] prdata, r;
   logic        pready, pslverr, ext0, ext1, v, hi, irq, svc_done, vbus_level, thi, ok, serr;
   logic [3:0]  id, tid;
   logic [7:0]  grant, src_req;
   int          n_fail     = 0;
   int          num_checks = 0;
   int          n0, n1;
   eipc_row_s   rows [8]   = '{'{eipc_pkg::ADDR_PRIO1, 8'hff, 8'hff}, '{eipc_pkg::ADDR_PRIO1, 8'h5a, 8'h5a},
                               '{eipc_pkg::ADDR_ENABLE2, 8'hff, 8'h01}, '{eipc_pkg::ADDR_ENABLE2, 8'hfe, 8'h00},
                               '{eipc_pkg::ADDR_PRIO2, 8'hff, 8'h01}, '{eipc_pkg::ADDR_PRIO2, 8'hfe, 8'h00},
                               '{eipc_pkg::ADDR_PINCFG, 8'hc3, 8'hc3}, '{12'h100, 8'hff, 8'h00}};

   always #10 mclk = ~mclk;

   eipc_top uut (
      .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin(port0_pin),
      .periph_want_pin(want_pin), .periph_pin_grant(grant), .ext_in_edge_mode(edge_mode),
      .ext_in_zero(ext0), .ext_in_one(ext1), .src_req(src_req), .src_en(src_en), .vbus_level(vbus_level),
      .svc_done(svc_done), .cpu_irq_valid(v), .cpu_irq_high(hi), .cpu_irq_id(id), .irq(irq)
   );

   eipc_src_model model (
      .mclk(mclk), .rst_n(rst_n), .want(want), .cpu_irq_valid(v), .cpu_irq_id(id),
      .src_req(src_req), .vbus_level(vbus_level), .svc_done(svc_done)
   );

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // records only the first request taken within the window
   task take;
      ok = 1'b0;
      repeat (30) begin
         @(posedge mclk);
         if (v === 1'b1 && ok === 1'b0) begin
            ok  = 1'b1;
            thi = hi;
            tid = id;
         end
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      summarize;
   end

   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, eipc_pkg::ADDR_PRIO1, 8'h00);
      chk(r, 32'h0000_0000, "prio1 reset");
      apb(1'b0, eipc_pkg::ADDR_ENABLE2, 8'h00);
      chk(r, 32'h0000_0000, "enable2 reset");
      apb(1'b0, eipc_pkg::ADDR_PRIO2, 8'h00);
      chk(r, 32'h0000_0000, "prio2 reset");
      apb(1'b0, eipc_pkg::ADDR_PINCFG, 8'h00);
      chk(r, 32'h0000_0001, "pin config reset");
      $display("reset values done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 8'h00);
         chk(r, {24'h00_0000, rows[i].e}, "register row");
      end
      chk({31'h0, serr}, 32'h0000_0000, "unmapped no error");
      $display("register rows done");
      // skip mask stays set so sampling is shown to ignore routing
      apb(1'b1, eipc_pkg::ADDR_SKIP, 8'h55);
      @(negedge mclk);
      chk({24'h00_0000, grant}, 32'h0000_00aa, "grant with skip");
      for (int p = 0; p < 8; p++) begin
         port0_pin <= 8'h01 << p;
         apb(1'b1, eipc_pkg::ADDR_PINCFG, {1'b1, 3'(p), 1'b1, 3'(p + 1)});
         repeat (4) @(posedge mclk);
         chk({30'h0, ext1, ext0}, 32'h0000_0002, "active high select");
         apb(1'b1, eipc_pkg::ADDR_PINCFG, {1'b0, 3'(p), 1'b0, 3'(p + 1)});
         repeat (4) @(posedge mclk);
         chk({30'h0, ext1, ext0}, 32'h0000_0001, "active low select");
      end
      apb(1'b1, eipc_pkg::ADDR_SKIP, 8'h00);
      @(negedge mclk);
      chk({24'h00_0000, grant}, 32'h0000_00ff, "grant no skip");
      $display("pin tests done");
      // edge mode: one pulse per asserted-going transition
      @(posedge mclk);
      port0_pin <= 8'h00;
      edge_mode <= 2'b11;
      apb(1'b1, eipc_pkg::ADDR_PINCFG, 8'h88);
      repeat (4) @(posedge mclk);
      port0_pin <= 8'h01;
      n0 = 0;
      n1 = 0;
      repeat (8) begin
         @(posedge mclk);
         if (ext0 === 1'b1) begin
            n0++;
         end
         if (ext1 === 1'b1) begin
            n1++;
         end
      end
      chk(n0, 32'h0000_0001, "input zero edge pulses");
      chk(n1, 32'h0000_0001, "input one edge pulses");
      edge_mode <= 2'b00;
      repeat (2) @(posedge mclk);
      chk({30'h0, ext1, ext0}, 32'h0000_0003, "level mode held");
      $display("edge mode tests done");
      apb(1'b1, eipc_pkg::ADDR_GLOBAL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, eipc_pkg::ADDR_PRIO1, 8'h01 << i);
         want <= 9'h0ff;
         take;
         chk({26'h0, ok, thi, tid}, {26'h0, 2'b11, 4'(i)}, "high first");
         want <= 9'h000;
         repeat (10) @(posedge mclk);
      end
      $display("priority tests done");
      apb(1'b1, eipc_pkg::ADDR_PRIO1, 8'h00);
      apb(1'b1, eipc_pkg::ADDR_ENABLE2, 8'h00);
      apb(1'b1, eipc_pkg::ADDR_PRIO2, 8'h01);
      want <= 9'h100;
      take;
      chk({31'h0, ok}, 32'h0000_0000, "bus voltage blocked");
      apb(1'b1, eipc_pkg::ADDR_ENABLE2, 8'h01);
      take;
      chk({26'h0, ok, thi, tid}, 32'h0000_0038, "bus voltage high");
      want <= 9'h000;
      repeat (10) @(posedge mclk);
      $display("bus voltage tests done");
      apb(1'b1, eipc_pkg::ADDR_GLOBAL, 8'h00);
      apb(1'b1, eipc_pkg::ADDR_IRQ_STAT, 8'h07);
      apb(1'b1, eipc_pkg::ADDR_IRQ_MASK, 8'h02);
      want <= 9'h0ff;
      take;
      chk({30'h0, ok, irq}, 32'h0000_0000, "global gate");
      apb(1'b1, eipc_pkg::ADDR_GLOBAL, 8'h01);
      take;
      chk({26'h0, ok, thi, tid}, 32'h0000_0020, "low lowest index");
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0000_0001, "irq raised");
      apb(1'b0, eipc_pkg::ADDR_IRQ_STAT, 8'h00);
      chk(r, 32'h0000_0002, "low taken status");
      apb(1'b1, eipc_pkg::ADDR_IRQ_MASK, 8'h00);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0000_0000, "irq masked");
      want <= 9'h000;
      repeat (10) @(posedge mclk);
      apb(1'b1, eipc_pkg::ADDR_IRQ_STAT, 8'h07);
      apb(1'b1, eipc_pkg::ADDR_IRQ_MASK, 8'h02);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
      $display("interrupt tests done");
      // low source taken first, bus voltage high arrives during its service
      apb(1'b1, eipc_pkg::ADDR_IRQ_STAT, 8'h07);
      want <= 9'h101;
      take;
      chk({26'h0, ok, thi, tid}, 32'h0000_0020, "low before late high");
      apb(1'b0, eipc_pkg::ADDR_IRQ_STAT, 8'h00);
      chk(r, 32'h0000_0007, "preempt status");
      want <= 9'h000;
      repeat (10) @(posedge mclk);
      $display("preempt tests done");
      apb(1'b1, eipc_pkg::ADDR_PRIO1, 8'hff);
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, eipc_pkg::ADDR_PRIO1, 8'h00);
      chk(r, 32'h0000_0000, "prio1 after reset");
      apb(1'b0, eipc_pkg::ADDR_PINCFG, 8'h00);
      chk(r, 32'h0000_0001, "pin config after reset");
      $display("mid-run reset done");
      summarize;
   end
endmodule // eipc_top_test
